// *** include/wol_pkg.sv ***
// Package: constants and types of the wake-on-LAN indication block
package wol_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int          ADDR_W      = 14;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [11:0] IDX_CFG     = 12'h4A0;
  localparam logic [11:0] IDX_STS     = 12'h4A1;
  localparam logic [11:0] IDX_PW0     = 12'h4A5;
  localparam logic [11:0] IDX_PW1     = 12'h4A6;
  localparam logic [11:0] IDX_PW2     = 12'h4A7;
  localparam logic [11:0] IDX_IRQ_STS = 12'h4B0;
  localparam logic [11:0] IDX_IRQ_EN  = 12'h4B1;
  localparam logic [11:0] IDX_IRQ_CLR = 12'h4B2;

  // ----------------------------------------
  // Config fields and reset
  // ----------------------------------------
  localparam int          CFG_CRC_GATE = 12;
  localparam int          CFG_LVL_CLR  = 11;
  localparam int          CFG_WIDTH_LO = 9;
  localparam int          CFG_STYLE    = 8;
  localparam int          CFG_WOL_EN   = 7;
  localparam int          CFG_BITMASK  = 6;
  localparam int          CFG_SECURE   = 5;
  localparam int          CFG_MAGIC_EN = 0;
  localparam logic [15:0] CFG_RESET    = 16'h1081;
  localparam logic [15:0] CFG_RW_MASK  = 16'h17E1;

  // ----------------------------------------
  // Status fields and reset
  // ----------------------------------------
  localparam int          STS_ROUTE    = 12;
  localparam int          STS_SFD      = 7;
  localparam int          STS_CRC      = 6;
  localparam int          STS_HACK     = 5;
  localparam int          STS_MAGIC    = 0;
  localparam logic [15:0] STS_RESET    = 16'h1000;

  // ----------------------------------------
  // Interrupt bits
  // ----------------------------------------
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_MAGIC    = 0;
  localparam int          IRQ_HACK     = 1;
  localparam int          IRQ_CRC      = 2;
  localparam int          IRQ_SFD      = 3;

  // ----------------------------------------
  // Pulse timing: widths set in wake-clock cycles, counted in aclk cycles
  // ----------------------------------------
  localparam int          WAKE_CLK_PS  = 8000;
  localparam int          ACLK_PS      = 10000;
  localparam int          PULSE_BASE   = 8;
  localparam int          CNT_W        = 7;
  localparam int          PULSE_CNT0   = (PULSE_BASE * 1 * WAKE_CLK_PS + ACLK_PS - 1) / ACLK_PS;
  localparam int          PULSE_CNT1   = (PULSE_BASE * 2 * WAKE_CLK_PS + ACLK_PS - 1) / ACLK_PS;
  localparam int          PULSE_CNT2   = (PULSE_BASE * 4 * WAKE_CLK_PS + ACLK_PS - 1) / ACLK_PS;
  localparam int          PULSE_CNT3   = (PULSE_BASE * 8 * WAKE_CLK_PS + ACLK_PS - 1) / ACLK_PS;

  // ----------------------------------------
  // Received-frame verdict from the receive filter
  // ----------------------------------------
  typedef struct packed {
    logic        done;
    logic        magic;
    logic        crc_bad;
    logic        sfd_err;
    logic [47:0] password;
  } wol_frame_t;

endpackage : wol_pkg

// *** rtl/wol_indication.sv ***
// Wake-on-LAN indication: registers, frame checks, interrupts
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module wol_indication (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave
  input  wire logic [wol_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [wol_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [wol_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [wol_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Receive filter verdict and side inputs
  input  wire wol_pkg::wol_frame_t       frame,
  input  wire logic                      magic_enable_strap,
  input  wire logic                      polarity_irq,
  // Outputs
  output logic                           wake_out,
  output logic                           irq,
  output logic                           isr_bit1
);
  import wol_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [REG_W-1:0]  cfg_q;
  logic              strap_done_q;
  logic              strap_meta_q;
  logic              strap_sync_q;
  logic              route_q;
  logic              sfd_q;
  logic              crc_q;
  logic              hack_q;
  logic              magic_q;
  logic [REG_W-1:0]  pw_q [3];
  logic [IRQ_W-1:0]  irq_st_q;
  logic [IRQ_W-1:0]  irq_en_q;
  logic [IRQ_W-1:0]  irq_ev;
  logic              irq_q;
  logic              isr_bit1_q;

  logic              aw_have_q;
  logic              w_have_q;
  logic [11:0]       aw_idx_q;
  logic [REG_W-1:0]  wdata_q;
  logic [1:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  logic              do_wr;
  logic              rd_fire;
  logic [11:0]       ar_idx;
  logic              wr_cfg;
  logic              wr_sts;
  logic              wr_irq_en;
  logic              wr_irq_clr;
  logic              wr_hit;
  logic              rd_sts;
  logic              rd_hit;
  logic [REG_W-1:0]  cfg_new;
  logic [REG_W-1:0]  rd_val;

  logic              gated;
  logic              pw_ok;
  logic              magic_ev;
  logic              magic_ok;
  logic              hack_ev;
  logic              crc_ev;
  logic              sfd_ev;
  logic              wake_fire;
  logic              lvl_clr;

  // ----------------------------------------
  // Byte-lane merge for 16-bit registers
  // ----------------------------------------
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                             input logic [REG_W-1:0] new_v,
                                             input logic [1:0]       strb);
    merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready  = ~w_have_q;
  assign do_wr         = aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[ADDR_W-1:2];
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata[REG_W-1:0];
      wstrb_q  <= s_axi_wstrb[1:0];
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  assign wr_cfg     = do_wr && aw_idx_q == IDX_CFG;
  assign wr_sts     = do_wr && aw_idx_q == IDX_STS;
  assign wr_irq_en  = do_wr && aw_idx_q == IDX_IRQ_EN;
  assign wr_irq_clr = do_wr && aw_idx_q == IDX_IRQ_CLR;
  assign wr_hit     = aw_idx_q == IDX_CFG || aw_idx_q == IDX_STS || aw_idx_q == IDX_PW0 ||
                      aw_idx_q == IDX_PW1 || aw_idx_q == IDX_PW2 || aw_idx_q == IDX_IRQ_EN ||
                      aw_idx_q == IDX_IRQ_CLR;
  assign cfg_new    = merge(cfg_q, wdata_q, wstrb_q) & CFG_RW_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign rd_fire       = s_axi_arvalid & ~rvalid_q;
  assign ar_idx        = s_axi_araddr[ADDR_W-1:2];
  assign rd_sts        = rd_fire && ar_idx == IDX_STS;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (ar_idx)
      IDX_CFG:     rd_val = cfg_q;
      IDX_STS: begin
        rd_val[STS_ROUTE] = route_q;
        rd_val[STS_SFD]   = sfd_q;
        rd_val[STS_CRC]   = crc_q;
        rd_val[STS_HACK]  = hack_q;
        rd_val[STS_MAGIC] = magic_q;
      end
      IDX_PW0:     rd_val = pw_q[0];
      IDX_PW1:     rd_val = pw_q[1];
      IDX_PW2:     rd_val = pw_q[2];
      IDX_IRQ_STS: rd_val = REG_W'(irq_st_q);
      IDX_IRQ_EN:  rd_val = REG_W'(irq_en_q);
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= DATA_W'(rd_val);
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  // Strap pin synchroniser; no reset, so it settles while reset is held
  always_ff @(posedge aclk) begin
    strap_meta_q <= magic_enable_strap;
    strap_sync_q <= strap_meta_q;
  end

  // Strap is caught on the first edge after release, never under reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q        <= CFG_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (wr_cfg) begin
        cfg_q <= cfg_new;
      end else if (!strap_done_q) begin
        cfg_q[CFG_MAGIC_EN] <= strap_sync_q;
      end
    end
  end

  // Self-clearing: bit reads 0, only the write matters
  assign lvl_clr = wr_cfg & wstrb_q[1] & wdata_q[CFG_LVL_CLR] & cfg_q[CFG_STYLE];

  // ----------------------------------------
  // Password words
  // ----------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_pw
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pw_q[i] <= '0;
      end else if (do_wr && aw_idx_q == IDX_PW0 + 12'(i)) begin
        pw_q[i] <= merge(pw_q[i], wdata_q, wstrb_q);
      end
    end
  end

  // ----------------------------------------
  // Frame evaluation
  // ----------------------------------------
  assign gated     = cfg_q[CFG_CRC_GATE] & frame.crc_bad;
  assign pw_ok     = frame.password == {pw_q[2], pw_q[1], pw_q[0]};
  assign magic_ev  = frame.done & frame.magic & cfg_q[CFG_WOL_EN] & ~gated;
  assign magic_ok  = magic_ev & (~cfg_q[CFG_SECURE] | pw_ok);
  assign hack_ev   = magic_ev & cfg_q[CFG_SECURE] & ~pw_ok;
  assign crc_ev    = frame.done & frame.crc_bad;
  assign sfd_ev    = frame.done & frame.sfd_err;
  assign wake_fire = magic_ok & cfg_q[CFG_MAGIC_EN];

  // ----------------------------------------
  // Wake status register
  // ----------------------------------------
  // Read clears the sticky flags, but a same-cycle event still wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sfd_q   <= STS_RESET[STS_SFD];
      crc_q   <= STS_RESET[STS_CRC];
      magic_q <= STS_RESET[STS_MAGIC];
    end else begin
      sfd_q   <= sfd_ev | (sfd_q & ~rd_sts);
      crc_q   <= crc_ev | (crc_q & ~rd_sts);
      magic_q <= magic_ok | (magic_q & ~rd_sts);
    end
  end

  // Follows the last checked magic frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hack_q <= STS_RESET[STS_HACK];
    end else if (hack_ev) begin
      hack_q <= 1'b1;
    end else if (magic_ev && cfg_q[CFG_SECURE]) begin
      hack_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= STS_RESET[STS_ROUTE];
    end else if (wr_cfg && cfg_new[CFG_WOL_EN] && !cfg_q[CFG_WOL_EN]) begin
      route_q <= 1'b1;
    end else if (wr_sts && wstrb_q[1]) begin
      route_q <= wdata_q[STS_ROUTE];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    irq_ev            = '0;
    irq_ev[IRQ_MAGIC] = wake_fire;
    irq_ev[IRQ_HACK]  = hack_ev;
    irq_ev[IRQ_CRC]   = crc_ev;
    irq_ev[IRQ_SFD]   = sfd_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
    end else begin
      irq_st_q <= irq_ev | (irq_st_q & ~(wr_irq_clr && wstrb_q[0] ? wdata_q[IRQ_W-1:0] : '0));
      if (wr_irq_en && wstrb_q[0]) begin
        irq_en_q <= wdata_q[IRQ_W-1:0];
      end
    end
  end

  // Registered so both outputs change on the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q      <= 1'b0;
      isr_bit1_q <= 1'b0;
    end else begin
      irq_q      <= |(irq_st_q & irq_en_q);
      isr_bit1_q <= route_q ? |(irq_st_q & irq_en_q) : polarity_irq;
    end
  end

  assign irq      = irq_q;
  assign isr_bit1 = isr_bit1_q;

  // ----------------------------------------
  // Wake output stage
  // ----------------------------------------
  wol_pulse u_pulse (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .fire       (wake_fire),
    .level_mode (cfg_q[CFG_STYLE]),
    .width_sel  (cfg_q[CFG_WIDTH_LO +: 2]),
    .level_clr  (lvl_clr),
    .wake_out   (wake_out)
  );

endmodule : wol_indication

// *** rtl/wol_pulse.sv ***
// Wake indication output stage: timed pulse or held level
`timescale 1ns/1ns
module wol_pulse (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       fire,
  input  wire logic       level_mode,
  input  wire logic [1:0] width_sel,
  input  wire logic       level_clr,
  output logic            wake_out
);
  import wol_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load_cnt;
  logic             wake_q;

  // ----------------------------------------
  // Width lookup
  // ----------------------------------------
  always_comb begin
    unique case (width_sel)
      2'h0: load_cnt = CNT_W'(PULSE_CNT0);
      2'h1: load_cnt = CNT_W'(PULSE_CNT1);
      2'h2: load_cnt = CNT_W'(PULSE_CNT2);
      2'h3: load_cnt = CNT_W'(PULSE_CNT3);
    endcase
  end

  // ----------------------------------------
  // Counter and output
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      wake_q <= 1'b0;
    end else if (level_mode) begin
      cnt_q  <= '0;
      wake_q <= fire | (wake_q & ~level_clr);
    end else begin
      cnt_q  <= fire ? load_cnt : (cnt_q != '0 ? cnt_q - CNT_W'(1) : '0);
      wake_q <= fire | (cnt_q > CNT_W'(1));
    end
  end

  assign wake_out = wake_q;

endmodule : wol_pulse

// *** test/wol_host_model.sv ***
// Host model: counts wake indications and measures pulse width
`timescale 1ns/1ns
module wol_host_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       wake_out,
  output logic      [7:0] wake_cnt,
  output logic      [7:0] wake_width
);
  logic [7:0] run_q;
  logic       prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q      <= 8'h00;
      prev_q     <= 1'b0;
      wake_cnt   <= 8'h00;
      wake_width <= 8'h00;
    end else begin
      prev_q <= wake_out;
      run_q  <= wake_out ? run_q + 8'h01 : 8'h00;
      if (wake_out && !prev_q) wake_cnt <= wake_cnt + 8'h01;
      if (!wake_out && prev_q) wake_width <= run_q;
    end
  end
endmodule : wol_host_model

// *** test/wol_indication_props.sv ***
// Checker: port properties of the wake-on-LAN indication block
`timescale 1ns/1ns
module wol_indication_props
  import wol_pkg::*;
(
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic [wol_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic [wol_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire wol_pkg::wol_frame_t        frame,
  input wire logic                       magic_enable_strap,
  input wire logic                       polarity_irq,
  input wire logic                       wake_out,
  input wire logic                       irq,
  input wire logic                       isr_bit1
);
  // ----
  // Config shadow, updated on the edge the write lands
  // ----
  logic [11:0] ai_q;
  logic [15:0] wd_q, cfg_q;
  logic        aw_q, w_q, route_q, first_q, st1_q, st2_q;
  logic [6:0]  hi_q, exp_w;
  wire         land;
  assign land = aw_q && w_q && !s_axi_bvalid;
  assign exp_w = 7'((PULSE_BASE * (32'd1 << cfg_q[10:9]) * WAKE_CLK_PS + ACLK_PS - 1) / ACLK_PS);

  // Full strobes assumed: the bench never writes partial words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      cfg_q   <= CFG_RESET;
      route_q <= 1'b1;
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
      if (first_q) cfg_q[CFG_MAGIC_EN] <= st2_q;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        ai_q <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata[15:0];
      end
      if (land) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        if (ai_q == IDX_CFG) cfg_q <= wd_q & CFG_RW_MASK;
        if (ai_q == IDX_CFG && wd_q[CFG_WOL_EN] && !cfg_q[CFG_WOL_EN]) route_q <= 1'b1;
        if (ai_q == IDX_STS) route_q <= wd_q[STS_ROUTE];
      end
    end
  end

  always_ff @(posedge aclk) begin
    hi_q  <= (aresetn && wake_out) ? hi_q + 7'h01 : 7'h00;
    st1_q <= magic_enable_strap;
    st2_q <= st1_q;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_magic_ok;
    frame.done && frame.magic && !frame.crc_bad && !frame.sfd_err && cfg_q[CFG_WOL_EN] &&
    cfg_q[CFG_MAGIC_EN] && !cfg_q[CFG_SECURE];
  endsequence
  sequence s_clr_lands;
    land && ai_q == IDX_CFG && wd_q[CFG_LVL_CLR] && cfg_q[CFG_STYLE];
  endsequence

  property p_crc_gate;
    frame.done && frame.crc_bad && cfg_q[CFG_CRC_GATE] && !wake_out |=> !wake_out;
  endproperty
  property p_wol_off;
    frame.done && !cfg_q[CFG_WOL_EN] && !wake_out |=> !wake_out;
  endproperty
  property p_fire;
    s_magic_ok |=> wake_out;
  endproperty
  property p_width;
    $fell(wake_out) && !cfg_q[CFG_STYLE] |-> hi_q == exp_w;
  endproperty
  property p_lvl_hold;
    wake_out && cfg_q[CFG_STYLE] && !s_axi_awvalid && !$past(s_axi_awvalid) && !s_axi_bvalid &&
    !$past(s_axi_bvalid) |=> wake_out;
  endproperty
  property p_lvl_clr;
    s_clr_lands |-> ##[1:3] !wake_out;
  endproperty
  property p_route;
    !route_q |=> isr_bit1 == $past(polarity_irq);
  endproperty
  property p_rst;
    $rose(aresetn) |-> !wake_out && !irq && !isr_bit1;
  endproperty

  a_crc_gate: assert property (p_crc_gate) else $error("wake raised on gated bad-CRC frame");
  a_wol_off: assert property (p_wol_off) else $error("wake raised with detection off");
  a_fire: assert property (p_fire) else $error("qualifying magic frame gave no wake");
  a_width: assert property (p_width) else $error("wake pulse width wrong");
  a_lvl_hold: assert property (p_lvl_hold) else $error("held wake level dropped");
  a_lvl_clr: assert property (p_lvl_clr) else $error("level clear did not drop wake");
  a_route: assert property (p_route) else $error("isr bit1 not polarity source");
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule : wol_indication_props

bind wol_indication wol_indication_props props_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .frame,
  .magic_enable_strap, .polarity_irq, .wake_out, .irq, .isr_bit1);

// *** test/wol_indication_tb.sv ***
// Testbench: wake-on-LAN indication block
`timescale 1ns/1ns
module wol_indication_tb;
  import wol_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0, polarity_irq = 1'b0, strap = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              wake_out, irq, isr_bit1;
  wol_frame_t        frame = '0;
  logic [7:0]        wake_cnt, wake_width, k;
  logic [47:0]       pw;
  logic [31:0]       rv;
  int                fail_count = 0, checked = 0, seed = 59508;
  // Cases: config, {magic, bad crc, sfd error, wrong password}, wake expected, status
  logic [15:0] t_cfg [7] = '{16'h1081, 16'h0081, 16'h1081, 16'h10A1, 16'h10A1, 16'h1001, 16'h1080};
  logic [3:0]  t_f [7]   = '{4'hC, 4'hC, 4'h2, 4'h9, 4'h8, 4'h8, 4'h8};
  logic [15:0] t_sts [7] = '{16'h1040, 16'h1041, 16'h1080, 16'h1020, 16'h1001, 16'h1000, 16'h1001};
  logic [6:0]  t_wk      = 7'h12;

  always #5 aclk = ~aclk;

  // Strobes tied: the bench writes whole words only
  wol_indication dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .frame, .magic_enable_strap(strap), .polarity_irq, .wake_out, .irq, .isr_bit1);
  wol_host_model host_u (.aclk, .aresetn, .wake_out, .wake_cnt, .wake_width);

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] exp_w(input logic [1:0] sel);
    return 32'((PULSE_BASE * (32'd1 << sel) * WAKE_CLK_PS + ACLK_PS - 1) / ACLK_PS);
  endfunction : exp_w

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] ix, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= {ix, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] ix, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic wrq(input logic [11:0] ix, input logic [31:0] d);
    logic [1:0] r;
    wr(ix, d, r);
  endtask : wrq

  task automatic rdc(input string nm, input logic [11:0] ix, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ix, d, r);
    chk(nm, d, e);
  endtask : rdc

  // Longest pulse is 52 cycles, so 70 leaves the output settled
  task automatic fr(input logic [3:0] f, input logic [47:0] p);
    @(posedge aclk);
    frame <= {1'b1, f[3:1], p};
    @(posedge aclk);
    frame.done <= 1'b0;
    repeat (70) @(posedge aclk);
  endtask : fr

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("cfg_reset", IDX_CFG, 32'h1081);
    rdc("sts_reset", IDX_STS, 32'h1000);
    pw = 48'({$random(seed), $random(seed)});
    for (int i = 0; i < 3; i++) wrq(IDX_PW0 + 12'(i), {16'h0, pw[16*i +: 16]});
    for (int i = 0; i < 3; i++) rdc("pw", IDX_PW0 + 12'(i), {16'h0, pw[16*i +: 16]});
    wrq(IDX_IRQ_EN, 32'h0000000F);
    k = 8'h00;
    for (int i = 0; i < 4; i++) begin
      wrq(IDX_CFG, 32'h1081 | (32'(i) << 9));
      fr(4'h8, 48'({$random(seed), $random(seed)}));
      k++;
      chk("width", {24'h0, wake_width}, exp_w(2'(i)));
      chk("irq", {31'h0, irq}, 32'h1);
      rdc("sts_magic", IDX_STS, 32'h1001);
      wrq(IDX_IRQ_CLR, 32'h0000000F);
      repeat (3) @(posedge aclk);
      chk("irq_clear", {31'h0, irq}, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      wrq(IDX_CFG, {16'h0, t_cfg[i]});
      rdc("cfg", IDX_CFG, {16'h0, t_cfg[i]});
      fr(t_f[i], t_f[i][0] ? ~pw : pw);
      k += 8'(t_wk[i]);
      chk("wakes", {24'h0, wake_cnt}, {24'h0, k});
      rdc("sts", IDX_STS, {16'h0, t_sts[i]});
    end
    wrq(IDX_CFG, 32'h1181);
    fr(4'h8, pw);
    k++;
    chk("level", {31'h0, wake_out}, 32'h1);
    wrq(IDX_CFG, 32'h1981);
    repeat (3) @(posedge aclk);
    chk("level_clear", {31'h0, wake_out}, 32'h0);
    rdc("cfg_clr", IDX_CFG, 32'h1181);
    chk("wakes", {24'h0, wake_cnt}, {24'h0, k});
    rdc("sts_lvl", IDX_STS, 32'h1001);
    wrq(IDX_STS, 32'h0);
    rdc("route0", IDX_STS, 32'h0);
    repeat (8) begin
      @(posedge aclk);
      polarity_irq <= 1'($random(seed));
      repeat (2) @(posedge aclk);
      chk("isr_bit1", {31'h0, isr_bit1}, {31'h0, polarity_irq});
    end
    wrq(IDX_CFG, 32'h1101);
    wrq(IDX_CFG, 32'h1181);
    rdc("route1", IDX_STS, 32'h1000);
    chk("isr_wake", {31'h0, isr_bit1}, 32'h1);
    rdc("irq_sts", IDX_IRQ_STS, 32'h0000000F);
    rdc("irq_en", IDX_IRQ_EN, 32'h0000000F);
    wr(12'h001, 32'hFFFF, rsp);
    chk("wr_unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd(IDX_IRQ_CLR, rv, rsp);
    chk("rd_clear_reg", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("rd_clear_data", rv, 32'h0);
    // Second reset with the strap low: magic enable must come up clear
    @(posedge aclk);
    aresetn <= 1'b0;
    strap   <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("cfg_strap", IDX_CFG, 32'h1080);
    rdc("sts_reset2", IDX_STS, 32'h1000);
    chk("irq_reset", {31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule : wol_indication_tb
